// >>> pkg/dcau_defs.svh
// constants of the central arithmetic unit: field positions, reset values, encodings
// assumes inclusion by every file of the block before use
// Summary of operation
// - scaling shifter moves a 16-bit data word left 0 to 16, zeros below.
// - upper scaler bits sign-extend when sign extension mode set, else zero.
// - alu takes accumulator plus shifted product or scaler output, result to accumulator.
// - stores of accumulator halves shift left 0 to 7, accumulator untouched.
// - upper half store pulls in lower bits; lower half store pulls in zeros.
// - carry changes on arithmetic, shifts, rotates, accumulation; not loads, logic, plain multiply.
// - carry set on add carry out; after subtract carry cleared on borrow.
// - add with carry and subtract with borrow use the previous carry.
// - upper half add only sets carry; upper half subtract only clears it.
// - hardware reset forces carry to one.
// - set carry, clear carry and status word load of carry exist.
// - one-bit right shift arithmetic when sign extension set, logical otherwise.
// - left shift inserts zero; shifts and rotates go through carry.
// - normalize shifts the accumulator left to normalize it.
// - variable shift ops use low four temp register bits as scaler count.
// - saturation mode on overflow sets flag and loads extreme value; ops toggle it.
// - branch conditions on carry, no carry, overflow, zero, and accumulator target.
// - multiplier forms 32-bit product of temp register and operand in one cycle.
// - temp load then multiply, or immediate multiply, gives a product every two cycles.
// - multiply-accumulate takes program and data bus operands each cycle.
// - multiplies are signed except the unsigned multiply.
// - square add and square subtract feed one data value to both inputs.
// - product shift select: 00 none, 01 left 1, 10 left 4, 11 right 6.
// - six-bit product right shift always sign-extends.
`ifndef DCAU_DEFS_SVH
`define DCAU_DEFS_SVH
`define DCAU_CARRY_RST    1'b1
`define DCAU_OVF_RST      1'b0
`define DCAU_SAT_RST      1'b0
`define DCAU_SXM_RST      1'b1
`define DCAU_PSEL_RST     2'b00
`define DCAU_ST1_CARRY_BIT 9
`define DCAU_ACC_MAX      32'h7FFF_FFFF
`define DCAU_ACC_MIN      32'h8000_0000
`define DCAU_PSHIFT_L4    4
`define DCAU_PSHIFT_R6    6
`endif

// >>> pkg/dcau_pkg.sv
// types of the central arithmetic unit: operation codes and the decoded command carrier
// assumes the instruction decoder fills dcau_cmd_type once per instruction cycle
package dcau_pkg;
  typedef enum logic [4:0] {
    OP_NOP        = 5'b0_0000,
    OP_LOAD       = 5'b0_0001,
    OP_ADD        = 5'b0_0010,
    OP_SUB        = 5'b0_0011,
    OP_ADD_CARRY  = 5'b0_0100,
    OP_SUB_BORROW = 5'b0_0101,
    OP_ADD_UPPER  = 5'b0_0110,
    OP_SUB_UPPER  = 5'b0_0111,
    OP_AND        = 5'b0_1000,
    OP_OR         = 5'b0_1001,
    OP_XOR        = 5'b0_1010,
    OP_SHL1       = 5'b0_1011,
    OP_SHR1       = 5'b0_1100,
    OP_ROL        = 5'b0_1101,
    OP_ROR        = 5'b0_1110,
    OP_NORMALIZE_OP       = 5'b0_1111,
    OP_LOAD_TEMP  = 5'b1_0000,
    OP_MULT       = 5'b1_0001,
    OP_MULT_U     = 5'b1_0010,
    OP_MAC        = 5'b1_0011,
    OP_SQR_ADD    = 5'b1_0100,
    OP_SQR_SUB    = 5'b1_0101,
    OP_APAC       = 5'b1_0110,
    OP_SPAC       = 5'b1_0111,
    OP_SET_CARRY  = 5'b1_1000,
    OP_CLR_CARRY  = 5'b1_1001,
    OP_LOAD_ST1   = 5'b1_1010,
    OP_SAT_ON     = 5'b1_1011,
    OP_SAT_OFF    = 5'b1_1100,
    OP_LOAD_PSEL  = 5'b1_1101,
    OP_LOAD_SXM   = 5'b1_1110
  } dcau_op_type;

  typedef struct packed {
    dcau_op_type op;
    logic        var_shift;
    logic [4:0]  shift;
    logic        use_product;
    logic [15:0] data;
    logic [15:0] prog;
    logic [2:0]  store_shift;
  } dcau_cmd_type;

  typedef struct packed {
    logic cond_carry;
    logic cond_no_carry;
    logic cond_overflow;
    logic cond_zero;
  } dcau_flags_type;
endpackage : dcau_pkg

// >>> logic/dcau_core.sv
// central arithmetic unit: scaler, alu, accumulator, store shifters, multiplier
// assumes decoded commands arrive synchronously on I_SYS_CLK, one per enabled cycle
`timescale 1ns/100ps
`include "dcau_defs.svh"
module dcau_core (
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_RSTN,
  input  wire logic                 I_CE,
  input  wire logic                 I_CMD_VALID,
  input  wire dcau_pkg::dcau_cmd_type I_CMD,
  output logic [31:0]               O_ACC,
  output logic [31:0]               O_PRODUCT,
  output logic [15:0]               O_TEMP,
  output logic [15:0]               O_STORE_UPPER,
  output logic [15:0]               O_STORE_LOWER,
  output logic [15:0]               O_BRANCH_TARGET,
  output dcau_pkg::dcau_flags_type  O_FLAGS,
  output logic                      O_CARRY,
  output logic                      O_OVERFLOW,
  output logic                      O_SAT_ENABLE,
  output logic                      O_SIGN_EXT_MODE,
  output logic [1:0]                O_PRODUCT_SHIFT_SEL
);
  logic [31:0] acc_q, acc_d, prod_q, prod_d;
  logic [15:0] temp_q;
  logic        carry_q, carry_d, ovf_q, ovf_d, sat_q, sxm_q;
  logic [1:0]  psel_q;
  logic [15:0] st_up_q, st_lo_q;
  logic [47:0] store_up_wide;
  logic [31:0] store_lo_wide;
  dcau_pkg::dcau_flags_type flags_q;
  logic [3:0]  shift_cnt;
  logic [31:0] scaled, pshifted, operand;
  logic [32:0] sum;
  logic        en;
  dcau_pkg::dcau_op_type op;

  assign en = I_CE && I_CMD_VALID;
  assign op = I_CMD.op;

  // ==========================================================
  // input scaling shifter and product shift stage
  always_comb begin
    logic [31:0] ext;
    ext = sxm_q ? {{16{I_CMD.data[15]}}, I_CMD.data} : {16'h0000, I_CMD.data};
    if (I_CMD.var_shift) begin
      ext = ext << shift_cnt;
    end else if (I_CMD.shift[4]) begin
      ext = {I_CMD.data, 16'h0000};
    end else begin
      ext = ext << I_CMD.shift[3:0];
    end
    scaled = ext;
  end
  assign shift_cnt = temp_q[3:0];

  always_comb begin
    unique case (psel_q)
      2'b00: pshifted = prod_q;
      2'b01: pshifted = {prod_q[30:0], 1'b0};
      2'b10: pshifted = {prod_q[27:0], 4'h0};
      2'b11: pshifted = {{6{prod_q[31]}}, prod_q[31:6]};
    endcase
  end

  // ==========================================================
  // alu
  always_comb begin
    logic sub;
    logic [31:0] b;
    logic [32:0] ovf_sum;
    sub = (op == dcau_pkg::OP_SUB) || (op == dcau_pkg::OP_SUB_BORROW) || (op == dcau_pkg::OP_SUB_UPPER)
       || (op == dcau_pkg::OP_SQR_SUB) || (op == dcau_pkg::OP_SPAC);
    operand = (I_CMD.use_product || op == dcau_pkg::OP_MAC || op == dcau_pkg::OP_SQR_ADD
       || op == dcau_pkg::OP_SQR_SUB || op == dcau_pkg::OP_APAC || op == dcau_pkg::OP_SPAC)
       ? pshifted : scaled;
    if (op == dcau_pkg::OP_ADD_UPPER || op == dcau_pkg::OP_SUB_UPPER) begin
      operand = {I_CMD.data, 16'h0000};
    end
    b = sub ? ~operand : operand;
    // borrow-in for subtract is the inverse of carry, so carry_q feeds both forms
    sum = {1'b0, acc_q} + {1'b0, b}
        + ((op == dcau_pkg::OP_ADD_CARRY || op == dcau_pkg::OP_SUB_BORROW) ? {32'h0000_0000, carry_q}
           : {32'h0000_0000, sub});
    ovf_sum = sum;
    acc_d = acc_q;
    carry_d = carry_q;
    ovf_d = ovf_q;
    unique case (op)
      dcau_pkg::OP_LOAD: acc_d = scaled;
      dcau_pkg::OP_ADD, dcau_pkg::OP_SUB, dcau_pkg::OP_ADD_CARRY, dcau_pkg::OP_SUB_BORROW,
      dcau_pkg::OP_MAC, dcau_pkg::OP_SQR_ADD, dcau_pkg::OP_SQR_SUB, dcau_pkg::OP_APAC,
      dcau_pkg::OP_SPAC: begin
        acc_d = ovf_sum[31:0];
        carry_d = sum[32];
        if ((acc_q[31] == b[31]) && (ovf_sum[31] != acc_q[31])) begin
          ovf_d = 1'b1;
          if (sat_q) begin
            acc_d = acc_q[31] ? `DCAU_ACC_MIN : `DCAU_ACC_MAX;
          end
        end
      end
      dcau_pkg::OP_ADD_UPPER, dcau_pkg::OP_SUB_UPPER: begin
        acc_d = ovf_sum[31:0];
        if (op == dcau_pkg::OP_ADD_UPPER && sum[32]) begin
          carry_d = 1'b1;
        end
        if (op == dcau_pkg::OP_SUB_UPPER && !sum[32]) begin
          carry_d = 1'b0;
        end
        if ((acc_q[31] == b[31]) && (ovf_sum[31] != acc_q[31])) begin
          ovf_d = 1'b1;
          if (sat_q) begin
            acc_d = acc_q[31] ? `DCAU_ACC_MIN : `DCAU_ACC_MAX;
          end
        end
      end
      dcau_pkg::OP_AND: acc_d = acc_q & {16'h0000, I_CMD.data};
      dcau_pkg::OP_OR:  acc_d = acc_q | {16'h0000, I_CMD.data};
      dcau_pkg::OP_XOR: acc_d = acc_q ^ {16'h0000, I_CMD.data};
      dcau_pkg::OP_SHL1: begin
        acc_d = {acc_q[30:0], 1'b0};
        carry_d = acc_q[31];
      end
      dcau_pkg::OP_SHR1: begin
        acc_d = {sxm_q & acc_q[31], acc_q[31:1]};
        carry_d = acc_q[0];
      end
      dcau_pkg::OP_ROL: begin
        acc_d = {acc_q[30:0], carry_q};
        carry_d = acc_q[31];
      end
      dcau_pkg::OP_ROR: begin
        acc_d = {carry_q, acc_q[31:1]};
        carry_d = acc_q[0];
      end
      dcau_pkg::OP_NORMALIZE_OP: begin
        if (acc_q[31] == acc_q[30] && acc_q != 32'h0000_0000) begin
          acc_d = {acc_q[30:0], 1'b0};
        end
      end
      dcau_pkg::OP_SET_CARRY: carry_d = 1'b1;
      dcau_pkg::OP_CLR_CARRY: carry_d = 1'b0;
      dcau_pkg::OP_LOAD_ST1:  carry_d = I_CMD.data[`DCAU_ST1_CARRY_BIT];
      default: ;
    endcase
  end

  // ==========================================================
  // multiplier
  always_comb begin
    logic [15:0] a, m;
    a = temp_q;
    m = I_CMD.data;
    prod_d = prod_q;
    if (op == dcau_pkg::OP_MAC) begin
      a = I_CMD.data;
      m = I_CMD.prog;
    end
    if (op == dcau_pkg::OP_SQR_ADD || op == dcau_pkg::OP_SQR_SUB) begin
      a = I_CMD.data;
    end
    if (op == dcau_pkg::OP_MULT || op == dcau_pkg::OP_MAC || op == dcau_pkg::OP_SQR_ADD
        || op == dcau_pkg::OP_SQR_SUB) begin
      prod_d = $signed({{16{a[15]}}, a}) * $signed({{16{m[15]}}, m});
    end else if (op == dcau_pkg::OP_MULT_U) begin
      prod_d = {16'h0000, a} * {16'h0000, m};
    end
  end

  // ==========================================================
  // state
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      acc_q <= 32'h0000_0000;
      carry_q <= `DCAU_CARRY_RST;
      ovf_q <= `DCAU_OVF_RST;
    end else if (en) begin
      acc_q <= acc_d;
      carry_q <= carry_d;
      ovf_q <= ovf_d;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      prod_q <= 32'h0000_0000;
      temp_q <= 16'h0000;
    end else if (en) begin
      prod_q <= prod_d;
      if (op == dcau_pkg::OP_LOAD_TEMP || op == dcau_pkg::OP_MAC) begin
        temp_q <= I_CMD.data;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      sat_q <= `DCAU_SAT_RST;
      sxm_q <= `DCAU_SXM_RST;
      psel_q <= `DCAU_PSEL_RST;
    end else if (en) begin
      if (op == dcau_pkg::OP_SAT_ON) sat_q <= 1'b1;
      if (op == dcau_pkg::OP_SAT_OFF) sat_q <= 1'b0;
      if (op == dcau_pkg::OP_LOAD_SXM) sxm_q <= I_CMD.data[0];
      if (op == dcau_pkg::OP_LOAD_PSEL) psel_q <= I_CMD.data[1:0];
    end
  end

  // ==========================================================
  // branch conditions are registered so every output leaves a flip-flop
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      flags_q.cond_carry    <= `DCAU_CARRY_RST;
      flags_q.cond_no_carry <= !`DCAU_CARRY_RST;
      flags_q.cond_overflow <= `DCAU_OVF_RST;
      flags_q.cond_zero     <= 1'b1;
    end else if (en) begin
      flags_q.cond_carry    <= carry_d;
      flags_q.cond_no_carry <= !carry_d;
      flags_q.cond_overflow <= ovf_d;
      flags_q.cond_zero     <= acc_d == 32'h0000_0000;
    end
  end

  // ==========================================================
  // store shifters: view of the value the accumulator holds after this edge
  always_comb begin
    logic [31:0] acc_new;
    acc_new = en ? acc_d : acc_q;
    store_up_wide = {16'h0000, acc_new} << I_CMD.store_shift;
    store_lo_wide = {16'h0000, acc_new[15:0]} << I_CMD.store_shift;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      st_up_q <= 16'h0000;
      st_lo_q <= 16'h0000;
    end else if (I_CE) begin
      st_up_q <= store_up_wide[31:16];
      st_lo_q <= store_lo_wide[15:0];
    end
  end

  assign O_ACC = acc_q;
  assign O_PRODUCT = prod_q;
  assign O_TEMP = temp_q;
  assign O_STORE_UPPER = st_up_q;
  assign O_STORE_LOWER = st_lo_q;
  assign O_BRANCH_TARGET = acc_q[15:0];
  assign O_FLAGS = flags_q;
  assign O_CARRY = carry_q;
  assign O_OVERFLOW = ovf_q;
  assign O_SAT_ENABLE = sat_q;
  assign O_SIGN_EXT_MODE = sxm_q;
  assign O_PRODUCT_SHIFT_SEL = psel_q;

  // ==========================================================
  // checks
  property p_carry_reset;
    @(posedge I_SYS_CLK) !I_RSTN |=> carry_q;
  endproperty
  a_carry_reset: assert property (p_carry_reset) else $error("carry not one after reset");

  property p_set_carry;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN) en && op == dcau_pkg::OP_SET_CARRY |=> O_CARRY;
  endproperty
  a_set_carry: assert property (p_set_carry) else $error("set carry failed");

  property p_logic_keeps_carry;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      en && (op == dcau_pkg::OP_AND || op == dcau_pkg::OP_LOAD || op == dcau_pkg::OP_MULT) |=> $stable(carry_q);
  endproperty
  a_logic_keeps_carry: assert property (p_logic_keeps_carry) else $error("carry changed");

  property p_shl_carry;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      en && op == dcau_pkg::OP_SHL1 |=> carry_q == $past(acc_q[31]) && acc_q[0] == 1'b0;
  endproperty
  a_shl_carry: assert property (p_shl_carry) else $error("left shift wrong");

  property p_shr_sign;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      en && op == dcau_pkg::OP_SHR1 |=> acc_q[31] == ($past(sxm_q) & $past(acc_q[31]));
  endproperty
  a_shr_sign: assert property (p_shr_sign) else $error("right shift sign wrong");

  property p_add_upper_no_clear;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN) en && op == dcau_pkg::OP_ADD_UPPER && carry_q |=> carry_q;
  endproperty
  a_add_upper_no_clear: assert property (p_add_upper_no_clear) else $error("upper add cleared carry");

  property p_unsigned_mult;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      en && op == dcau_pkg::OP_MULT_U |=> prod_q == {16'h0000, $past(temp_q)} * {16'h0000, $past(I_CMD.data)};
  endproperty
  a_unsigned_mult: assert property (p_unsigned_mult) else $error("unsigned product wrong");

  property p_psel_r6;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN) psel_q == 2'b11 |-> $signed(pshifted) == ($signed(prod_q) >>> 6);
  endproperty
  a_psel_r6: assert property (p_psel_r6) else $error("product right shift not signed");

  property p_mac_operands;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      en && op == dcau_pkg::OP_MAC |=> $signed(prod_q) == $signed($past(I_CMD.data)) * $signed($past(I_CMD.prog))
      && temp_q == $past(I_CMD.data);
  endproperty
  a_mac_operands: assert property (p_mac_operands) else $error("multiply-accumulate operands wrong");

  property p_saturate;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      en && sat_q && op == dcau_pkg::OP_ADD && acc_q[31] == 1'b0 && operand[31] == 1'b0 && sum[31]
      |=> acc_q == `DCAU_ACC_MAX && ovf_q;
  endproperty
  a_saturate: assert property (p_saturate) else $error("no positive saturation");
endmodule : dcau_core

// >>> bench/dcau_decoder_model.sv
// decoder model: hands the core one decoded command per cycle
// assumes the bench calls issue and idle; all driving is on the falling edge
`timescale 1ns/100ps
module dcau_decoder_model (
  input  wire logic                  i_clk,
  output logic                       o_ce,
  output logic                       o_valid,
  output dcau_pkg::dcau_cmd_type     o_cmd
);
  // ==========================================================
  // drive tasks
  initial begin
    o_ce    = 1'b1;
    o_valid = 1'b0;
    o_cmd   = '0;
  end
  task automatic issue(input dcau_pkg::dcau_cmd_type c, input logic ce);
    @(negedge i_clk);
    o_ce    <= ce;
    o_valid <= 1'b1;
    o_cmd   <= c;
  endtask : issue
  // a released bus shows the inverted last command, never the last command
  task automatic idle();
    @(negedge i_clk);
    o_valid <= 1'b0;
    o_cmd   <= ~o_cmd;
  endtask : idle
endmodule : dcau_decoder_model

// >>> bench/dcau_core_tb.sv
// testbench of the central arithmetic unit: directed corners, random commands, then a reset and saturation corners
// assumes the core answers one cycle after each enabled command
`timescale 1ns/100ps
`include "dcau_defs.svh"
module dcau_core_tb;
  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] prod;
    logic [15:0] tmp;
    logic        c, ov, sat, sign_ext_mode;
    logic [1:0]  ps;
    logic [15:0] su, sl;
  } dcau_ref_type;
  logic clk, rst_n, ce, valid, carry, ovf, sat, sign_ext_mode;
  logic [31:0] acc, prod;
  logic [15:0] temp, su, sl, bt;
  logic [1:0]  psel;
  logic [4:0]  v;
  dcau_pkg::dcau_cmd_type   cmd, c;
  dcau_pkg::dcau_flags_type flags;
  dcau_ref_type m;
  int fail_count = 0;
  int cmp_count  = 0;
  dcau_decoder_model dec (.i_clk(clk), .o_ce(ce), .o_valid(valid), .o_cmd(cmd));
  dcau_core dut (.I_SYS_CLK(clk), .I_RSTN(rst_n), .I_CE(ce), .I_CMD_VALID(valid), .I_CMD(cmd),
    .O_ACC(acc), .O_PRODUCT(prod), .O_TEMP(temp), .O_STORE_UPPER(su), .O_STORE_LOWER(sl),
    .O_BRANCH_TARGET(bt), .O_FLAGS(flags), .O_CARRY(carry), .O_OVERFLOW(ovf),
    .O_SAT_ENABLE(sat), .O_SIGN_EXT_MODE(sign_ext_mode), .O_PRODUCT_SHIFT_SEL(psel));
  // ==========================================================
  // expectation functions
  function automatic logic [31:0] pshift(input logic [31:0] p, input logic [1:0] s);
    case (s)
      2'b01:   return p << 1;
      2'b10:   return p << 4;
      2'b11:   return $signed(p) >>> 6;
      default: return p;
    endcase
  endfunction : pshift
  function automatic dcau_ref_type step(input dcau_ref_type s, input dcau_pkg::dcau_cmd_type k);
    logic [4:0]  o;
    logic [31:0] op, t;
    logic [32:0] r;
    logic        ad, ov;
    o  = k.op;
    t  = {{16{s.sign_ext_mode & k.data[15]}}, k.data};
    op = t << (k.var_shift ? {1'b0, s.tmp[3:0]} : k.shift);
    if (k.use_product || o inside {[5'h13:5'h17]}) op = pshift(s.prod, s.ps);
    if (o inside {5'h06, 5'h07}) op = {k.data, 16'h0000};
    ad = o inside {5'h02, 5'h04, 5'h06, 5'h13, 5'h14, 5'h16};
    if (ad || o inside {5'h03, 5'h05, 5'h07, 5'h15, 5'h17}) begin
      r  = ad ? s.acc + op + 33'(o == 5'h04 && s.c) : s.acc - op - 33'(o == 5'h05 && !s.c);
      ov = (s.acc[31] == (op[31] ^ !ad)) && (r[31] != s.acc[31]);
      s.ov  = s.ov | ov;
      s.acc = (ov && s.sat) ? (r[31] ? `DCAU_ACC_MAX : `DCAU_ACC_MIN) : r[31:0];
      if (o == 5'h06) s.c = s.c | r[32];
      else if (o == 5'h07) s.c = s.c & !r[32];
      else s.c = ad ? r[32] : !r[32];
    end
    case (o)
      5'h01: s.acc = op;
      5'h08: s.acc = s.acc & {16'h0000, k.data};
      5'h09: s.acc = s.acc | {16'h0000, k.data};
      5'h0A: s.acc = s.acc ^ {16'h0000, k.data};
      5'h0B: {s.c, s.acc} = {s.acc, 1'b0};
      5'h0C: {s.acc, s.c} = {s.sign_ext_mode & s.acc[31], s.acc};
      5'h0D: {s.c, s.acc} = {s.acc, s.c};
      5'h0E: {s.acc, s.c} = {s.c, s.acc};
      5'h0F: if (s.acc[31] == s.acc[30]) s.acc = s.acc << 1;
      5'h10: s.tmp = k.data;
      5'h11: s.prod = $signed(s.tmp) * $signed(k.data);
      5'h12: s.prod = s.tmp * k.data;
      5'h13: s.prod = $signed(k.data) * $signed(k.prog);
      5'h14, 5'h15: s.prod = $signed(k.data) * $signed(k.data);
      5'h18: s.c = 1'b1;
      5'h19: s.c = 1'b0;
      5'h1A: s.c = k.data[`DCAU_ST1_CARRY_BIT];
      5'h1B: s.sat = 1'b1;
      5'h1C: s.sat = 1'b0;
      5'h1D: s.ps = k.data[1:0];
      5'h1E: s.sign_ext_mode = k.data[0];
      default: ;
    endcase
    if (o == 5'h13) s.tmp = k.data;
    t    = s.acc << k.store_shift;
    s.su = t[31:16];
    s.sl = s.acc[15:0] << k.store_shift;
    return s;
  endfunction : step
  function automatic dcau_pkg::dcau_cmd_type mk(input dcau_pkg::dcau_op_type o, input logic [15:0] d,
                                                 input logic [4:0] sh = 5'h00);
    mk             = '0;
    mk.op          = o;
    mk.data        = d;
    mk.shift       = sh;
    mk.prog        = 16'($urandom);
    mk.store_shift = 3'($urandom_range(7));
  endfunction : mk
  // ==========================================================
  // compare tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cmp_state(input bit ca, input bit cc);
    if (ca) begin
      check(acc, m.acc);
      check({su, sl}, {m.su, m.sl});
      check({bt, 15'h0000, flags.cond_zero}, {m.acc[15:0], 15'h0000, m.acc == 32'h0000_0000});
    end
    if (cc) check(32'({flags.cond_carry, flags.cond_no_carry, carry}), 32'({m.c, !m.c, m.c}));
    check(prod, m.prod);
    check(32'({temp, sat, sign_ext_mode, psel}), 32'({m.tmp, m.sat, m.sign_ext_mode, m.ps}));
  endtask : cmp_state
  task automatic cmp_ovf();
    check(32'({ovf, flags.cond_overflow}), 32'({m.ov, m.ov}));
  endtask : cmp_ovf
  task automatic chk_reset();
    m     = '0;
    m.c   = `DCAU_CARRY_RST;
    m.sign_ext_mode = `DCAU_SXM_RST;
    cmp_state(1'b1, 1'b1);
    cmp_ovf();
  endtask : chk_reset
  task automatic run(input dcau_pkg::dcau_cmd_type k, input bit ca = 1'b1, input bit cc = 1'b1);
    dec.issue(k, 1'b1);
    m = step(m, k);
    @(posedge clk);
    #1;
    cmp_state(ca, cc);
  endtask : run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    void'($urandom(32'h4193_75c1));
    repeat (4) @(negedge clk);
    chk_reset();
    rst_n = 1'b1;
    run(mk(dcau_pkg::OP_LOAD, 16'hFFFF));
    run(mk(dcau_pkg::OP_ADD, 16'h0001));
    run(mk(dcau_pkg::OP_SUB, 16'h0001));
    run(mk(dcau_pkg::OP_ADD_CARRY, 16'h0000));
    run(mk(dcau_pkg::OP_SUB_UPPER, 16'h0001));
    run(mk(dcau_pkg::OP_NOP, 16'h1234));
    for (int i = 8; i < 11; i++) run(mk(dcau_pkg::dcau_op_type'(i), 16'($urandom)));
    run(mk(dcau_pkg::OP_LOAD, 16'h0001));
    run(mk(dcau_pkg::OP_NORMALIZE_OP, 16'h0000), 1'b1, 1'b0);
    run(mk(dcau_pkg::OP_SET_CARRY, 16'h0000));
    run(mk(dcau_pkg::OP_SAT_ON, 16'h0000));
    run(mk(dcau_pkg::OP_LOAD, 16'h4000, 5'd16));
    run(mk(dcau_pkg::OP_ADD, 16'h4000, 5'd16), 1'b1, 1'b0);
    cmp_ovf();
    run(mk(dcau_pkg::OP_CLR_CARRY, 16'h0000));
    run(mk(dcau_pkg::OP_LOAD, 16'h8000, 5'd16));
    run(mk(dcau_pkg::OP_SUB, 16'h0001), 1'b1, 1'b0);
    cmp_ovf();
    run(mk(dcau_pkg::OP_SAT_OFF, 16'h0000));
    run(mk(dcau_pkg::OP_SET_CARRY, 16'h0000));
    // clock enable low must freeze every register, store views included
    dec.issue(mk(dcau_pkg::OP_ADD, 16'h0101), 1'b0);
    @(posedge clk);
    #1;
    cmp_state(1'b1, 1'b1);
    repeat (400) begin
      do v = 5'($urandom_range(30, 1));
      while (v inside {5'h0F, 5'h1B, 5'h1C});
      c = mk(dcau_pkg::dcau_op_type'(v), 16'($urandom), 5'($urandom_range(16)));
      if (v inside {5'h01, 5'h02, 5'h03}) begin
        c.var_shift   = 1'($urandom);
        c.use_product = (v != 5'h01) && 1'($urandom);
      end else if (v inside {[5'h04:5'h07]}) begin
        c.shift = 5'h00;
      end
      run(c);
    end
    dec.idle();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk_reset();
    rst_n = 1'b1;
    run(mk(dcau_pkg::OP_ADD, 16'h7FFF, 5'd3));
    run(mk(dcau_pkg::OP_SAT_ON, 16'h0000));
    run(mk(dcau_pkg::OP_LOAD, 16'h7FFF, 5'd16));
    run(mk(dcau_pkg::OP_OR, 16'hFFFF));
    // saturating an accumulator already at its extreme must still raise overflow
    run(mk(dcau_pkg::OP_ADD, 16'h0001));
    cmp_ovf();
    dec.idle();
    report_and_stop();
  end
endmodule : dcau_core_tb
